//--- rtl/ccc_core.sv
// calendar clock core: registers, windows, write lock, calendar and output pin
//
// Operation
// - calendar runs 2000-01-01 through 2099-12-31
// - hours count 00 to 23
// - leap day inserted automatically
// - one-second steps, half-second phase visible
// - all time and alarm fields BCD
// - value pointer selects the value pair
// - value pointer counts down to 00
// - alarm pointer selects the alarm pair
// - alarm pointer counts down on high access
// - reads of either byte decrement pointer
// - time writes need value_write_unlock set
// - unlock set only right after key pair
// - run enable writable only when unlocked
// - locked value window writes are dropped
// - rollover pending flag read-only status
// - half-second phase, cleared by seconds write
// - pin output enable gates the pin
// - eight-bit drift trim applied automatically
// - config register cleared only by power-on
// - timing from 32.768 kHz crystal
// - signed trim, four pulses per step
// - pin source: seconds clock or alarm
`timescale 1ns/1ps
module ccc_core
   import ccc_pkg::*;
#(
   parameter int SEC_CYC = XTAL_HZ,
   parameter int SYNC_WINDOW = SYNC_WINDOW_DEF
)(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic por,
   input wire logic xtal_clk,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   output logic rtc_pin,
   output logic rtc_pin_oe_n
);

   // configuration, cleared by power-on only
   logic run_en;
   logic wr_unlock;
   logic pin_oe;
   logic [1:0] val_ptr;
   logic [7:0] trim;

   // alarm setup and pin select
   logic [5:0] alm_ctrl;
   logic [1:0] alm_ptr;
   logic [7:0] alm_rpt;
   logic pin_sel;
   ccc_alarm_t alm;

   ccc_time_t tm;
   ccc_time_t next_time;
   ccc_key_t key_state;

   logic half_phase;
   logic sec_tick;
   logic near_roll;
   logic alarm_pulse;
   logic restart;

   logic wr_cfg;
   logic wr_val_hi;
   logic wr_val_lo;
   logic rd_val_hi;
   logic rd_val_lo;
   logic wr_alm_hi;
   logic wr_alm_lo;
   logic rd_alm_hi;
   logic rd_alm_lo;
   logic wr_alm_setup;
   logic wr_key;
   logic wr_pin;

   assign wr_cfg = wr && (addr == REG_CFG);
   assign wr_val_hi = wr && (addr == REG_VAL_HIGH);
   assign wr_val_lo = wr && (addr == REG_VAL_LOW);
   assign rd_val_hi = rd && (addr == REG_VAL_HIGH);
   assign rd_val_lo = rd && (addr == REG_VAL_LOW);
   assign wr_alm_hi = wr && (addr == REG_ALM_HIGH);
   assign wr_alm_lo = wr && (addr == REG_ALM_LOW);
   assign rd_alm_hi = rd && (addr == REG_ALM_HIGH);
   assign rd_alm_lo = rd && (addr == REG_ALM_LOW);
   assign wr_alm_setup = wr && (addr == REG_ALM_SETUP);
   assign wr_key = wr && (addr == REG_KEY);
   assign wr_pin = wr && (addr == REG_PIN_CFG);

   // seconds write restarts the second
   assign restart = wr_val_lo && wr_unlock && (val_ptr == PTR_MIN_SEC);

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9)
         return {v[7:4] + 4'h1, 4'h0};
      else
         return {v[7:4], v[3:0] + 4'h1};
   endfunction

   // every fourth year of the century, 2000 included
   function automatic logic is_leap(input logic [7:0] y);
      if (y[4])
         return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      else
         return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
      case (m)
         8'h02: return is_leap(y) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction

   function automatic logic [7:0] pick(input logic [1:0] p, input logic [7:0] b0,
                                       input logic [7:0] b1, input logic [7:0] b2,
                                       input logic [7:0] b3);
      case (p)
         PTR_MIN_SEC: return b0;
         PTR_WDAY_HOUR: return b1;
         PTR_MONTH_DAY: return b2;
         default: return b3;
      endcase
   endfunction

   ccc_tick_gen #(
      .SEC_CYC(SEC_CYC),
      .SYNC_WINDOW(SYNC_WINDOW)
   ) u_tick (
      .sys_clk(sys_clk),
      .srst(srst || por),
      .run(run_en),
      .xtal_clk(xtal_clk),
      .restart(restart),
      .trim_now(tm.second == TRIM_SECOND),
      .trim(trim),
      .half_phase(half_phase),
      .sec_tick(sec_tick),
      .near_roll(near_roll)
   );

   // key sequence: 55h then aah, unlock only on the very next cycle
   always_ff @(posedge sys_clk)
   begin
      if (srst || por)
         key_state <= KEY_IDLE;
      else
      begin
         case (key_state)
            KEY_IDLE:
               if (wr_key && wdata[7:0] == KEY_FIRST)
                  key_state <= KEY_GOT_FIRST;
            KEY_GOT_FIRST:
               if (wr_key && wdata[7:0] == KEY_SECOND)
                  key_state <= KEY_ARMED;
               else if (wr_key && wdata[7:0] == KEY_FIRST)
                  key_state <= KEY_GOT_FIRST;
               else if (wr || rd)
                  key_state <= KEY_IDLE;
            KEY_ARMED:
               key_state <= KEY_IDLE;
            default:
               key_state <= KEY_IDLE;
         endcase
      end
   end

   // configuration register, untouched by srst
   always_ff @(posedge sys_clk)
   begin
      if (por)
      begin
         run_en <= 1'b0;
         wr_unlock <= 1'b0;
         pin_oe <= 1'b0;
         val_ptr <= PTR_MIN_SEC;
         trim <= '0;
      end
      else if (wr_cfg)
      begin
         if (wr_unlock)
            run_en <= wdata[BIT_RUN];
         if (!wdata[BIT_UNLOCK])
            wr_unlock <= 1'b0;
         else if (key_state == KEY_ARMED)
            wr_unlock <= 1'b1;
         pin_oe <= wdata[BIT_OE];
         val_ptr <= wdata[PTR_MSB:PTR_LSB];
         trim <= wdata[TRIM_MSB:0];
      end
      else if ((rd_val_hi || rd_val_lo || wr_val_hi) && val_ptr != PTR_MIN_SEC)
         val_ptr <= val_ptr - 2'h1;
   end

   // calendar roll, all fields bcd
   always_comb
   begin
      next_time = tm;
      if (tm.second == SEC_LAST)
      begin
         next_time.second = BCD_ZERO;
         if (tm.minute == MIN_LAST)
         begin
            next_time.minute = BCD_ZERO;
            if (tm.hour == HOUR_LAST)
            begin
               next_time.hour = BCD_ZERO;
               next_time.wday = (tm.wday == WDAY_LAST) ? BCD_ZERO : bcd_inc(tm.wday);
               if (tm.day == last_day(tm.month, tm.year))
               begin
                  next_time.day = BCD_ONE;
                  if (tm.month == MONTH_LAST)
                  begin
                     next_time.month = BCD_ONE;
                     next_time.year = (tm.year == YEAR_LAST) ? BCD_ZERO : bcd_inc(tm.year);
                  end
                  else
                     next_time.month = bcd_inc(tm.month);
               end
               else
                  next_time.day = bcd_inc(tm.day);
            end
            else
               next_time.hour = bcd_inc(tm.hour);
         end
         else
            next_time.minute = bcd_inc(tm.minute);
      end
      else
         next_time.second = bcd_inc(tm.second);
   end

   // time registers: locked writes dropped, writes win over a tick
   always_ff @(posedge sys_clk)
   begin
      if (srst || por)
         tm <= TIME_RESET;
      else if (wr_val_hi && wr_unlock)
      begin
         case (val_ptr)
            PTR_MIN_SEC: tm.minute <= wdata[7:0] & MASK_MIN;
            PTR_WDAY_HOUR: tm.wday <= wdata[7:0] & MASK_WDAY;
            PTR_MONTH_DAY: tm.month <= wdata[7:0] & MASK_MONTH;
            default: tm <= tm;
         endcase
      end
      else if (wr_val_lo && wr_unlock)
      begin
         case (val_ptr)
            PTR_MIN_SEC: tm.second <= wdata[7:0] & MASK_SEC;
            PTR_WDAY_HOUR: tm.hour <= wdata[7:0] & MASK_HOUR;
            PTR_MONTH_DAY: tm.day <= wdata[7:0] & MASK_DAY;
            default: tm.year <= wdata[7:0] & MASK_YEAR;
         endcase
      end
      else if (sec_tick)
         tm <= next_time;
   end

   // alarm setup and alarm values
   always_ff @(posedge sys_clk)
   begin
      if (srst || por)
      begin
         alm_ctrl <= '0;
         alm_ptr <= PTR_MIN_SEC;
         alm_rpt <= '0;
         alm <= '0;
      end
      else if (wr_alm_setup)
      begin
         alm_ctrl <= wdata[DATA_W-1:ALM_CTRL_LSB];
         alm_ptr <= wdata[PTR_MSB:PTR_LSB];
         alm_rpt <= wdata[TRIM_MSB:0];
      end
      else
      begin
         if (wr_alm_hi)
         begin
            case (alm_ptr)
               PTR_MIN_SEC: alm.minute <= wdata[7:0] & MASK_MIN;
               PTR_WDAY_HOUR: alm.wday <= wdata[7:0] & MASK_WDAY;
               PTR_MONTH_DAY: alm.month <= wdata[7:0] & MASK_MONTH;
               default: alm <= alm;
            endcase
         end
         else if (wr_alm_lo)
         begin
            case (alm_ptr)
               PTR_MIN_SEC: alm.second <= wdata[7:0] & MASK_SEC;
               PTR_WDAY_HOUR: alm.hour <= wdata[7:0] & MASK_HOUR;
               PTR_MONTH_DAY: alm.day <= wdata[7:0] & MASK_DAY;
               default: alm <= alm;
            endcase
         end
         if ((rd_alm_hi || rd_alm_lo || wr_alm_hi) && alm_ptr != PTR_MIN_SEC)
            alm_ptr <= alm_ptr - 2'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst || por)
         pin_sel <= 1'b0;
      else if (wr_pin)
         pin_sel <= wdata[PIN_SEL_BIT];
   end

   // alarm pulse lasts the matching second
   always_ff @(posedge sys_clk)
   begin
      if (srst || por)
         alarm_pulse <= 1'b0;
      else
         alarm_pulse <= run_en && alm_ctrl[ALM_EN_BIT] && tm.second == alm.second
                        && tm.minute == alm.minute && tm.hour == alm.hour;
   end

   // output pin, seconds clock high in the first half
   always_ff @(posedge sys_clk)
   begin
      if (srst || por)
      begin
         rtc_pin <= 1'b0;
         rtc_pin_oe_n <= 1'b1;
      end
      else
      begin
         rtc_pin <= pin_oe && (pin_sel ? !half_phase : alarm_pulse);
         rtc_pin_oe_n <= !pin_oe;
      end
   end

   // read data in the cycle after the strobe only
   always_ff @(posedge sys_clk)
   begin
      if (srst || por || !rd)
         rdata <= '0;
      else
      begin
         case (addr)
            REG_CFG:
               rdata <= {run_en, 1'b0, wr_unlock, near_roll, half_phase, pin_oe,
                         val_ptr, trim};
            REG_VAL_HIGH:
               rdata <= {8'h00, pick(val_ptr, tm.minute, tm.wday, tm.month, BCD_ZERO)};
            REG_VAL_LOW:
               rdata <= {8'h00, pick(val_ptr, tm.second, tm.hour, tm.day, tm.year)};
            REG_ALM_HIGH:
               rdata <= {8'h00, pick(alm_ptr, alm.minute, alm.wday, alm.month, BCD_ZERO)};
            REG_ALM_LOW:
               rdata <= {8'h00, pick(alm_ptr, alm.second, alm.hour, alm.day, BCD_ZERO)};
            REG_ALM_SETUP:
               rdata <= {alm_ctrl, alm_ptr, alm_rpt};
            REG_PIN_CFG:
               rdata <= {15'h0000, pin_sel};
            default:
               rdata <= '0;
         endcase
      end
   end

endmodule

//--- rtl/ccc_pkg.sv
// package: register map, field layout, calendar limits and timing for the calendar clock core
package ccc_pkg;

   // register bus
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] REG_CFG = 3'h0;
   localparam logic [ADDR_W-1:0] REG_VAL_HIGH = 3'h1;
   localparam logic [ADDR_W-1:0] REG_VAL_LOW = 3'h2;
   localparam logic [ADDR_W-1:0] REG_ALM_HIGH = 3'h3;
   localparam logic [ADDR_W-1:0] REG_ALM_LOW = 3'h4;
   localparam logic [ADDR_W-1:0] REG_ALM_SETUP = 3'h5;
   localparam logic [ADDR_W-1:0] REG_KEY = 3'h6;
   localparam logic [ADDR_W-1:0] REG_PIN_CFG = 3'h7;

   // calib_config_register, alarm setup and pin config fields
   localparam int BIT_RUN = 15;
   localparam int BIT_UNLOCK = 13;
   localparam int BIT_OE = 10;
   localparam int PTR_MSB = 9;
   localparam int PTR_LSB = 8;
   localparam int TRIM_MSB = 7;
   localparam int ALM_CTRL_LSB = 10;
   localparam int ALM_EN_BIT = 5;
   localparam int PIN_SEL_BIT = 0;

   // window pointer codes
   localparam logic [1:0] PTR_MIN_SEC = 2'h0;
   localparam logic [1:0] PTR_WDAY_HOUR = 2'h1;
   localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
   localparam logic [1:0] PTR_YEAR = 2'h3;

   // unlock key pair
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // bcd field masks and limits
   localparam logic [7:0] MASK_SEC = 8'h7f;
   localparam logic [7:0] MASK_MIN = 8'h7f;
   localparam logic [7:0] MASK_HOUR = 8'h3f;
   localparam logic [7:0] MASK_WDAY = 8'h07;
   localparam logic [7:0] MASK_DAY = 8'h3f;
   localparam logic [7:0] MASK_MONTH = 8'h1f;
   localparam logic [7:0] MASK_YEAR = 8'hff;
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] SEC_LAST = 8'h59;
   localparam logic [7:0] MIN_LAST = 8'h59;
   localparam logic [7:0] HOUR_LAST = 8'h23;
   localparam logic [7:0] WDAY_LAST = 8'h06;
   localparam logic [7:0] MONTH_LAST = 8'h12;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   localparam logic [7:0] TRIM_SECOND = 8'h00;

   // crystal timing
   localparam int XTAL_HZ = 32768;
   localparam int CNT_W = 16;
   localparam int TRIM_STEP = 4;
   localparam int SYNC_WINDOW_DEF = 32;

   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] wday;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } ccc_time_t;

   typedef struct packed {
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] wday;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } ccc_alarm_t;

   // saturday 2000-01-01 00:00:00
   localparam ccc_time_t TIME_RESET = '{8'h00, 8'h01, 8'h01, 8'h06, 8'h00, 8'h00, 8'h00};

   typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} ccc_key_t;

endpackage

//--- rtl/ccc_tick_gen.sv
// crystal edge counter giving half-second phase, second tick and rollover window
`timescale 1ns/1ps
module ccc_tick_gen
   import ccc_pkg::*;
#(
   parameter int SEC_CYC = XTAL_HZ,
   parameter int SYNC_WINDOW = SYNC_WINDOW_DEF
)(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic run,
   input wire logic xtal_clk,
   input wire logic restart,
   input wire logic trim_now,
   input wire logic [7:0] trim,
   output logic half_phase,
   output logic sec_tick,
   output logic near_roll
);

   logic xtal_prev;
   logic xtal_edge;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] period;

   // positive trim shortens the trimmed second, negative lengthens it
   function automatic logic [CNT_W-1:0] second_len(input logic apply, input logic [7:0] t);
      int len;
      len = SEC_CYC;
      if (apply)
         len = SEC_CYC - TRIM_STEP * int'($signed(t));
      return CNT_W'(len);
   endfunction

   assign xtal_edge = xtal_clk & ~xtal_prev;
   assign period = second_len(trim_now, trim);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         xtal_prev <= 1'b0;
      else
         xtal_prev <= xtal_clk;
   end

   // one second is SEC_CYC crystal edges, trimmed once a minute
   always_ff @(posedge sys_clk)
   begin
      if (srst || restart)
      begin
         cnt <= '0;
         sec_tick <= 1'b0;
      end
      else if (run && xtal_edge)
      begin
         if (cnt >= period - CNT_W'(1))
         begin
            cnt <= '0;
            sec_tick <= 1'b1;
         end
         else
         begin
            cnt <= cnt + CNT_W'(1);
            sec_tick <= 1'b0;
         end
      end
      else
         sec_tick <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst || restart)
      begin
         half_phase <= 1'b0;
         near_roll <= 1'b0;
      end
      else
      begin
         half_phase <= (cnt >= CNT_W'(SEC_CYC / 2));
         near_roll <= run && (cnt + CNT_W'(SYNC_WINDOW) >= period);
      end
   end

endmodule

//--- sim/ccc_core_props.sv
// checker: register bus, write lock and config behaviour of the calendar clock core
`timescale 1ns/1ps
module ccc_core_props
   import ccc_pkg::*;
#(
   parameter int SEC_CYC = XTAL_HZ,
   parameter int SYNC_WINDOW = SYNC_WINDOW_DEF
)(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic por,
   input wire logic xtal_clk,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic rtc_pin,
   input wire logic rtc_pin_oe_n
);
   logic first_d;
   logic key_hit;
   logic unlock_m;
   logic run_m;
   logic oe_m;
   logic [7:0] trim_m;
   wire cfg_wr = wr && addr == REG_CFG;
   wire cfg_rd = rd && addr == REG_CFG;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst || por);
   sequence key_pair;
      wr && addr == REG_KEY && wdata[7:0] == KEY_FIRST
         ##1 wr && addr == REG_KEY && wdata[7:0] == KEY_SECOND;
   endsequence
   // key history and config model
   always_ff @(posedge sys_clk)
   begin
      first_d <= wr && addr == REG_KEY && wdata[7:0] == KEY_FIRST;
      key_hit <= wr && addr == REG_KEY && wdata[7:0] == KEY_SECOND && first_d;
   end
   always_ff @(posedge sys_clk)
   begin
      if (por)
      begin
         unlock_m <= 1'b0;
         run_m <= 1'b0;
         oe_m <= 1'b0;
         trim_m <= 8'h00;
      end
      else if (cfg_wr)
      begin
         unlock_m <= wdata[BIT_UNLOCK] && (key_hit || unlock_m);
         if (unlock_m)
            run_m <= wdata[BIT_RUN];
         oe_m <= wdata[BIT_OE];
         trim_m <= wdata[TRIM_MSB:0];
      end
   end
   chk_rdata_idle: assert property (!rd |=> rdata == 16'h0)
      else $error("read data not zero outside answer cycle");
   chk_unlock_key: assert property (key_pair ##1 (cfg_wr && wdata[BIT_UNLOCK]) ##1 cfg_rd
      |=> rdata[BIT_UNLOCK])
      else $error("unlock not set after key pair");
   chk_unlock_model: assert property (cfg_rd |=> rdata[BIT_UNLOCK] == $past(unlock_m))
      else $error("unlock bit wrong");
   chk_run_locked: assert property (cfg_rd |=> rdata[BIT_RUN] == $past(run_m))
      else $error("run enable wrong");
   chk_cfg_fields: assert property (cfg_rd |=> rdata[BIT_OE] == $past(oe_m)
      && rdata[7:0] == $past(trim_m) && !rdata[14])
      else $error("config fields wrong");
   chk_sync_idle: assert property (cfg_rd && !run_m |=> !rdata[12])
      else $error("rollover flag set while stopped");
   chk_oe_pin: assert property (!$past(srst) && !$past(por)
      |-> rtc_pin_oe_n == !$past(oe_m))
      else $error("pin enable does not follow config");
   chk_pin_gated: assert property (rtc_pin_oe_n |-> !rtc_pin)
      else $error("pin active while output disabled");
   chk_key_read: assert property (rd && addr == REG_KEY |=> rdata == 16'h0)
      else $error("key register read not zero");
   chk_pin_cfg: assert property (rd && addr == REG_PIN_CFG |=> rdata[15:1] == 15'h0)
      else $error("pin config reserved bits set");
endmodule

bind ccc_core ccc_core_props #(.SEC_CYC(SEC_CYC), .SYNC_WINDOW(SYNC_WINDOW)) ccc_core_props_inst (
   .sys_clk(sys_clk), .srst(srst), .por(por), .xtal_clk(xtal_clk), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rtc_pin(rtc_pin),
   .rtc_pin_oe_n(rtc_pin_oe_n));

//--- sim/test_calendar_clock_core.sv
// testbench: registers, calendar rollover, trim and pin of the calendar clock core
`timescale 1ns/1ps
module test_calendar_clock_core
   import ccc_pkg::*;
;
   localparam int SEC = 16;
   localparam int XDIV = 8;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic por = 1'b1;
   logic xtal_clk = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic rtc_pin;
   logic rtc_pin_oe_n;
   logic rd_d = 1'b0;
   logic pin_d = 1'b0;
   logic [2:0] xcnt = '0;
   logic [31:0] exp_q[$];
   logic [31:0] r;
   logic [31:0] note;
   logic [7:0] trim = 8'h00;
   ccc_time_t start_t[3];
   ccc_time_t end_t[3];
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   int t0 = 0;
   int seed = 32'hb0b93e1a;

   ccc_core #(.SEC_CYC(SEC), .SYNC_WINDOW(2)) ccc_core_inst (
      .sys_clk(sys_clk), .srst(srst), .por(por), .xtal_clk(xtal_clk), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rtc_pin(rtc_pin),
      .rtc_pin_oe_n(rtc_pin_oe_n));

   initial
      forever #5 sys_clk = ~sys_clk;

   task summarize;
      if (miscompares == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
      checks++;
      if ((got & msk) !== (exp & msk))
      begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   // crystal, cycle count, timeout
   always @(posedge sys_clk)
   begin
      xcnt <= xcnt + 3'h1;
      xtal_clk <= xcnt[2];
      rd_d <= rd;
      pin_d <= rtc_pin;
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         summarize();
      end
   end

   // read answers against oldest note
   always @(negedge sys_clk)
   begin
      if (rd_d && exp_q.size() > 0)
      begin
         note = exp_q.pop_front();
         cmp(rdata, note[15:0], note[31:16]);
      end
   end

   task bus(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w,
            input logic rr);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= rr;
   endtask

   task rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e, input logic [15:0] m);
      exp_q.push_back({m, e});
      bus(a, 16'h0, 1'b0, 1'b1);
   endtask

   task cfg_wr(input logic [DATA_W-1:0] d);
      bus(REG_KEY, {8'h00, KEY_FIRST}, 1'b1, 1'b0);
      bus(REG_KEY, {8'h00, KEY_SECOND}, 1'b1, 1'b0);
      bus(REG_CFG, d, 1'b1, 1'b0);
   endtask

   function automatic logic [DATA_W-1:0] cfg_val(input logic [1:0] p);
      return 16'ha400 | {6'h0, p, trim};
   endfunction

   task set_time(input ccc_time_t t);
      cfg_wr(cfg_val(2'h3));
      bus(REG_VAL_LOW, {8'h0, t.year}, 1'b1, 1'b0);
      bus(REG_VAL_HIGH, 16'h0, 1'b1, 1'b0);
      bus(REG_VAL_LOW, {8'h0, t.day}, 1'b1, 1'b0);
      bus(REG_VAL_HIGH, {8'h0, t.month}, 1'b1, 1'b0);
      bus(REG_VAL_LOW, {8'h0, t.hour}, 1'b1, 1'b0);
      bus(REG_VAL_HIGH, {8'h0, t.wday}, 1'b1, 1'b0);
      bus(REG_VAL_LOW, {8'h0, t.second}, 1'b1, 1'b0);
      bus(REG_VAL_HIGH, {8'h0, t.minute}, 1'b1, 1'b0);
      bus(3'h0, 16'h0, 1'b0, 1'b0);
   endtask

   task check_time(input ccc_time_t t);
      cfg_wr(cfg_val(2'h3));
      rd_chk(REG_VAL_LOW, {8'h0, t.year}, 16'hffff);
      rd_chk(REG_VAL_HIGH, {8'h0, t.month}, 16'hffff);
      rd_chk(REG_VAL_LOW, {8'h0, t.hour}, 16'hffff);
      rd_chk(REG_VAL_LOW, {8'h0, t.second}, 16'hffff);
      rd_chk(REG_VAL_HIGH, {8'h0, t.minute}, 16'hffff);
      cfg_wr(cfg_val(2'h2));
      rd_chk(REG_VAL_LOW, {8'h0, t.day}, 16'hffff);
      rd_chk(REG_VAL_HIGH, {8'h0, t.wday}, 16'hffff);
      bus(3'h0, 16'h0, 1'b0, 1'b0);
   endtask

   task wait_rise;
      int n;
      n = 0;
      @(negedge sys_clk);
      while (!(rtc_pin === 1'b1 && pin_d === 1'b0))
      begin
         n++;
         if (n == 400)
         begin
            miscompares++;
            $display("BAD %0t no seconds clock edge", $time);
            return;
         end
         @(negedge sys_clk);
      end
   endtask

   initial
   begin
      start_t[0] = {8'h99, 8'h12, 8'h31, 8'h05, 8'h23, 8'h59, 8'h59};
      end_t[0] = {8'h00, 8'h01, 8'h01, 8'h06, 8'h00, 8'h00, 8'h01};
      start_t[1] = {8'h24, 8'h02, 8'h28, 8'h03, 8'h23, 8'h59, 8'h59};
      end_t[1] = {8'h24, 8'h02, 8'h29, 8'h04, 8'h00, 8'h00, 8'h01};
      start_t[2] = {8'h23, 8'h02, 8'h28, 8'h02, 8'h23, 8'h59, 8'h59};
      end_t[2] = {8'h23, 8'h03, 8'h01, 8'h03, 8'h00, 8'h00, 8'h01};
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      por <= 1'b0;
      rd_chk(REG_CFG, 16'h0, 16'hffff);
      rd_chk(REG_KEY, 16'h0, 16'hffff);
      bus(REG_CFG, 16'ha000, 1'b1, 1'b0);
      rd_chk(REG_CFG, 16'h0, 16'hffff);
      bus(REG_KEY, {8'h00, KEY_FIRST}, 1'b1, 1'b0);
      bus(REG_KEY, {8'h00, KEY_SECOND}, 1'b1, 1'b0);
      bus(3'h0, 16'h0, 1'b0, 1'b0);
      bus(REG_CFG, 16'h2000, 1'b1, 1'b0);
      rd_chk(REG_CFG, 16'h0, 16'hffff);
      bus(REG_VAL_LOW, 16'h0033, 1'b1, 1'b0);
      rd_chk(REG_VAL_LOW, 16'h0000, 16'hffff);
      bus(REG_PIN_CFG, 16'h0001, 1'b1, 1'b0);
      rd_chk(REG_PIN_CFG, 16'h0001, 16'hffff);
      bus(REG_ALM_SETUP, 16'h0200, 1'b1, 1'b0);
      bus(REG_ALM_HIGH, 16'h0011, 1'b1, 1'b0);
      bus(REG_ALM_LOW, 16'h0008, 1'b1, 1'b0);
      bus(REG_ALM_HIGH, 16'h0003, 1'b1, 1'b0);
      bus(REG_ALM_HIGH, 16'h0037, 1'b1, 1'b0);
      bus(REG_ALM_SETUP, 16'h0200, 1'b1, 1'b0);
      rd_chk(REG_ALM_HIGH, 16'h0011, 16'hffff);
      rd_chk(REG_ALM_LOW, 16'h0008, 16'hffff);
      rd_chk(REG_ALM_HIGH, 16'h0037, 16'hffff);
      rd_chk(REG_ALM_SETUP, 16'h0000, 16'hffff);
      cfg_wr(cfg_val(2'h3));
      rd_chk(REG_CFG, cfg_val(2'h3) & 16'h7fff, 16'he7ff);
      for (int i = 0; i < 3; i++)
      begin
         r = $random(seed);
         trim = {{7{r[1]}}, r[0]};
         set_time(start_t[i]);
         repeat (100) @(posedge sys_clk);
         wait_rise();
         t0 = cyc;
         wait_rise();
         cmp(16'(cyc - t0), 16'((SEC - 4 * int'($signed(trim))) * XDIV), 16'hffff);
         check_time(end_t[i]);
      end
      cmp({15'h0, rtc_pin_oe_n}, 16'h0, 16'h0001);
      repeat (60) @(posedge sys_clk);
      rd_chk(REG_CFG, cfg_val(2'h0) | 16'h0800, 16'hefff);
      bus(3'h0, 16'h0, 1'b0, 1'b0);
      repeat (40) @(posedge sys_clk);
      rd_chk(REG_CFG, cfg_val(2'h0) | 16'h1800, 16'hffff);
      bus(REG_VAL_LOW, 16'h0045, 1'b1, 1'b0);
      rd_chk(REG_CFG, cfg_val(2'h0), 16'hffff);
      cfg_wr(cfg_val(2'h0) & 16'hdfff);
      bus(REG_VAL_LOW, 16'h0030, 1'b1, 1'b0);
      rd_chk(REG_VAL_LOW, 16'h0045, 16'hffff);
      bus(REG_CFG, {8'h04, trim}, 1'b1, 1'b0);
      rd_chk(REG_CFG, {8'h84, trim}, 16'he7ff);
      bus(3'h0, 16'h0, 1'b0, 1'b0);
      srst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      rd_chk(REG_CFG, {8'h84, trim}, 16'he7ff);
      rd_chk(REG_VAL_LOW, 16'h0000, 16'hffff);
      rd_chk(REG_VAL_LOW, 16'h0000, 16'hffff);
      bus(3'h0, 16'h0, 1'b0, 1'b0);
      por <= 1'b1;
      repeat (3) @(posedge sys_clk);
      por <= 1'b0;
      rd_chk(REG_CFG, 16'h0, 16'hffff);
      bus(3'h0, 16'h0, 1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
      summarize();
   end
endmodule
